/* dsc_sequencer_display.sv */
// Purpose: Phase sequencer, result latch and direct display drive of a dual-slope converter.
// Assumes: core_clk is the oscillator input; compOut is synchronous to it.
// Notes: compOut high means the integrator output sits above its zero level.

`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Oscillator divided by four gives the count enable for the phase sequencer and result latch.
// R2: LCD backplane is a 50% square wave at oscillator over 800.
// R3: LCD segment equals backplane when off, inverted when on.
// R4: Minus sign lit for negative input, dark for positive.
// R5: Every segment of every digit has its own output, no multiplexing.
// R6: Leading half digit is one output lighting both segments of one.
// R7: Conversion cycle is always exactly 4000 counts.
// R8: Auto-zero lasts 100 counts after overrange, else 990 to 2990.
// R9: Deintegrate shortfall from 2000 is added to the next auto-zero.
// R10: Signal integrate always lasts 1000 counts.
// R11: Deintegrate lasts 1 to 2000 counts; its count less one is the reading.
// R12: Phase changes are decided from counters and the comparator.
// R13: Zero integrate lasts 10 counts, or 900 after overrange.
// R14: Reference cap charges in auto-zero and zero integrate, flies in deintegrate.
// R15: Phases run auto-zero, integrate, deintegrate, zero integrate, repeat.
// R16: Comparator sampled at end of integrate sets polarity and reference sign.
// R17: Zero crossing latches the deintegrate count, held until next conversion.
// R18: 2000 deintegrate counts without crossing is overrange.
// R19: After reset: auto-zero, counters cleared, display shows zero.
module dsc_sequencer_display #(
	parameter bit LCD_MODE = 1'b1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Analog front end
	input wire logic compOut,
	output logic autoZeroSwitch,
	output logic signalIntegrateSwitch,
	output logic refRampPosSwitch,
	output logic refRampNegSwitch,
	output logic dischargeSwitch,
	output logic refChargeSwitch,
	// Display
	output logic backplaneDrive,
	output logic [6:0] onesSegments,
	output logic [6:0] tensSegments,
	output logic [6:0] hundredsSegments,
	output logic halfDigitSegment,
	output logic minusSegment
);
	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [15:0] bcdInc(input logic [15:0] v);
		logic [15:0] r;
		logic carry;
		r = v;
		carry = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			if (carry)
			begin
				if (r[i*4 +: 4] == 4'h9)
					r[i*4 +: 4] = 4'h0;
				else
				begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcdInc

	function automatic logic atEnd(input logic [11:0] cnt, input logic [11:0] len);
		return cnt == len - 12'h001;
	endfunction : atEnd

	function automatic logic segLevel(input logic on, input logic bp);
		if (LCD_MODE)
			return on ^ bp;
		return ~on;
	endfunction : segLevel

	// ****************************************
	// Clock dividers
	// ****************************************
	// Divider runs free; the count enable is one core_clk wide
	localparam int unsigned BP_HALF = dsc_pkg::BP_DIV / 2;
	logic [1:0] divCnt_q;
	logic [8:0] bpCnt_q;
	logic bp_q;
	wire countEn = (divCnt_q == 2'(dsc_pkg::OSC_DIV - 1)); // [R1]
	wire bpWrap = (bpCnt_q == 9'(BP_HALF - 1));

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			divCnt_q <= 2'h0;
			bpCnt_q <= 9'h000;
			bp_q <= 1'b0;
		end
		else
		begin
			divCnt_q <= divCnt_q + 2'h1; // [R1]
			bpCnt_q <= bpWrap ? 9'h000 : bpCnt_q + 9'h001;
			if (bpWrap)
				bp_q <= ~bp_q; // [R2]
		end
	end

	// ****************************************
	// Phase sequencer
	// ****************************************
	dsc_pkg::dsc_phase_t phase_q;
	logic [11:0] phaseCnt_q;
	logic [15:0] bcdCnt_q;
	logic [11:0] azLen_q;
	logic [11:0] ziLen_q;
	logic negative_q;

	// Crossing: comparator has left the side it held at the end of integrate
	wire crossing = (compOut != negative_q);
	wire azDone = atEnd(phaseCnt_q, azLen_q); // [R8] [R12]
	wire intDone = atEnd(phaseCnt_q, dsc_pkg::INT_COUNTS); // [R10] [R12]
	// Deintegrate ends on a crossing or at full scale; a crossing on its first count reads zero
	wire deintEnd = crossing || atEnd(phaseCnt_q, dsc_pkg::DEINT_MAX); // [R11] [R12]
	wire overrange = !crossing; // [R18]
	wire ziDone = atEnd(phaseCnt_q, ziLen_q); // [R13] [R12]
	// Deintegrate lasted phaseCnt_q + 1 counts; the rest of 2000 goes to auto-zero
	wire [11:0] azNormal = dsc_pkg::AZ_BASE - phaseCnt_q - 12'h001; // [R9] [R7]

	logic phaseEnd;
	always_comb
	begin
		unique case (phase_q)
			dsc_pkg::PH_AUTOZERO: phaseEnd = azDone;
			dsc_pkg::PH_INTEGRATE: phaseEnd = intDone;
			dsc_pkg::PH_DEINTEGRATE: phaseEnd = deintEnd;
			dsc_pkg::PH_DISCHARGE: phaseEnd = ziDone;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q <= dsc_pkg::PH_AUTOZERO; // [R19]
			phaseCnt_q <= 12'h000;
			bcdCnt_q <= 16'h0000;
			// First auto-zero lasts one count longer than the one after a zero reading
			azLen_q <= dsc_pkg::AZ_RESET;
			ziLen_q <= dsc_pkg::ZI_NORMAL;
			negative_q <= 1'b0;
		end
		else if (countEn)
		begin
			if (phaseEnd)
			begin
				phaseCnt_q <= 12'h000;
				bcdCnt_q <= 16'h0000;
				unique case (phase_q) // [R15]
					dsc_pkg::PH_AUTOZERO: phase_q <= dsc_pkg::PH_INTEGRATE;
					dsc_pkg::PH_INTEGRATE:
					begin
						phase_q <= dsc_pkg::PH_DEINTEGRATE;
						negative_q <= compOut; // [R16]
					end
					dsc_pkg::PH_DEINTEGRATE:
					begin
						phase_q <= dsc_pkg::PH_DISCHARGE;
						ziLen_q <= overrange ? dsc_pkg::ZI_OVER : dsc_pkg::ZI_NORMAL; // [R13] [R18]
						azLen_q <= overrange ? dsc_pkg::AZ_OVER : azNormal; // [R8] [R9]
					end
					dsc_pkg::PH_DISCHARGE: phase_q <= dsc_pkg::PH_AUTOZERO;
				endcase
			end
			else
			begin
				phaseCnt_q <= phaseCnt_q + 12'h001;
				bcdCnt_q <= bcdInc(bcdCnt_q);
			end
		end
	end

	// ****************************************
	// Analog switch controls
	// ****************************************
	// Switches are decoded straight from the phase register
	wire inAz = (phase_q == dsc_pkg::PH_AUTOZERO);
	wire inDeint = (phase_q == dsc_pkg::PH_DEINTEGRATE);
	wire inZi = (phase_q == dsc_pkg::PH_DISCHARGE);
	assign autoZeroSwitch = inAz;
	assign signalIntegrateSwitch = (phase_q == dsc_pkg::PH_INTEGRATE);
	// Negative input ramped back with the positive reference and vice versa
	assign refRampPosSwitch = inDeint && negative_q; // [R14] [R16]
	assign refRampNegSwitch = inDeint && !negative_q; // [R14] [R16]
	assign dischargeSwitch = inZi;
	assign refChargeSwitch = inAz || inZi; // [R14]

	// ****************************************
	// Result latch
	// ****************************************
	logic [3:0] onesDig_q;
	logic [3:0] tensDig_q;
	logic [3:0] hundredsDig_q;
	logic half_q;
	logic minus_q;
	wire latchEn = countEn && inDeint && deintEnd; // [R17]
	// Overrange shows a lone leading one with the lower digits blank
	wire [3:0] nextOnes = overrange ? dsc_pkg::DIGIT_BLANK : bcdCnt_q[3:0]; // [R18]
	wire [3:0] nextTens = overrange ? dsc_pkg::DIGIT_BLANK : bcdCnt_q[7:4];
	wire [3:0] nextHundreds = overrange ? dsc_pkg::DIGIT_BLANK : bcdCnt_q[11:8];
	wire nextHalf = overrange || bcdCnt_q[12]; // [R6]

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			onesDig_q <= 4'h0; // [R19]
			tensDig_q <= 4'h0;
			hundredsDig_q <= 4'h0;
			half_q <= 1'b0;
			minus_q <= 1'b0;
		end
		else if (latchEn)
		begin
			onesDig_q <= nextOnes; // [R17] [R18]
			tensDig_q <= nextTens;
			hundredsDig_q <= nextHundreds;
			half_q <= nextHalf; // [R6]
			minus_q <= negative_q; // [R4]
		end
	end

	// ****************************************
	// Display drivers
	// ****************************************
	logic [6:0] onesDec;
	logic [6:0] tensDec;
	logic [6:0] hundredsDec;

	// Decoders blank any code above nine
	dsc_seg_decoder u_onesDec (
		.digit(onesDig_q),
		.segments(onesDec)
	);

	dsc_seg_decoder u_tensDec (
		.digit(tensDig_q),
		.segments(tensDec)
	);

	dsc_seg_decoder u_hundredsDec (
		.digit(hundredsDig_q),
		.segments(hundredsDec)
	);

	logic [6:0] onesSeg_q;
	logic [6:0] tensSeg_q;
	logic [6:0] hundredsSeg_q;
	logic halfSeg_q;
	logic minusSeg_q;
	logic bpOut_q;

	// Segment pins and backplane share one register stage so they never skew
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			onesSeg_q <= 7'h00;
			tensSeg_q <= 7'h00;
			hundredsSeg_q <= 7'h00;
			halfSeg_q <= 1'b0;
			minusSeg_q <= 1'b0;
			bpOut_q <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 7; i++)
			begin
				onesSeg_q[i] <= segLevel(onesDec[i], bp_q); // [R3] [R5]
				tensSeg_q[i] <= segLevel(tensDec[i], bp_q); // [R3] [R5]
				hundredsSeg_q[i] <= segLevel(hundredsDec[i], bp_q); // [R3] [R5]
			end
			halfSeg_q <= segLevel(half_q, bp_q); // [R6] [R3]
			minusSeg_q <= segLevel(minus_q, bp_q); // [R4] [R3]
			bpOut_q <= bp_q; // [R2]
		end
	end

	assign onesSegments = onesSeg_q;
	assign tensSegments = tensSeg_q;
	assign hundredsSegments = hundredsSeg_q;
	assign halfDigitSegment = halfSeg_q;
	assign minusSegment = minusSeg_q;
	assign backplaneDrive = LCD_MODE ? bpOut_q : 1'b0;
endmodule : dsc_sequencer_display

`default_nettype wire

/* dsc_seg_decoder.sv */
// Purpose: Shared constants of the converter control and a one-digit seven-segment decoder.
// Assumes: Digit code 4'hf means blank; codes 4'ha to 4'he never occur.
// Notes: Segment vector order is {g,f,e,d,c,b,a}, a bit high lights the segment.

// ****************************************
// Shared constants
// ****************************************
package dsc_pkg;
	localparam int unsigned OSC_DIV = 4;
	localparam int unsigned BP_DIV = 800;
	localparam int unsigned CYCLE_COUNTS = 4000;
	localparam logic [11:0] INT_COUNTS = 12'h3e8;
	localparam logic [11:0] DEINT_MAX = 12'h7d0;
	localparam logic [11:0] ZI_NORMAL = 12'h00a;
	localparam logic [11:0] ZI_OVER = 12'h384;
	localparam logic [11:0] AZ_OVER = 12'h064;
	localparam logic [11:0] AZ_BASE = 12'hbae;
	localparam logic [11:0] AZ_RESET = 12'hbae;
	localparam logic [3:0] DIGIT_BLANK = 4'hf;
	localparam logic [6:0] SEG_BLANK = 7'h00;
	typedef enum logic [1:0] {
		PH_AUTOZERO,
		PH_INTEGRATE,
		PH_DEINTEGRATE,
		PH_DISCHARGE
	} dsc_phase_t;
endpackage : dsc_pkg

`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Seven-segment decoder
// ****************************************
module dsc_seg_decoder (
	// Digit in
	input wire logic [3:0] digit,
	// Segments out
	output logic [6:0] segments
);
	function automatic logic [6:0] decode(input logic [3:0] d);
		unique case (d)
			4'h0: decode = 7'h3f;
			4'h1: decode = 7'h06;
			4'h2: decode = 7'h5b;
			4'h3: decode = 7'h4f;
			4'h4: decode = 7'h66;
			4'h5: decode = 7'h6d;
			4'h6: decode = 7'h7d;
			4'h7: decode = 7'h07;
			4'h8: decode = 7'h7f;
			4'h9: decode = 7'h6f;
			default: decode = dsc_pkg::SEG_BLANK;
		endcase
	endfunction : decode

	assign segments = decode(digit);
endmodule : dsc_seg_decoder

`default_nettype wire

/* dsc_seq_checker.sv */
// Purpose: Phase timing checks of the converter sequencer.
// Assumes: Bound into every sequencer instance.
// Notes: Lengths are counted in core_clk edges, four to a count.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module dsc_seq_checker #(
	parameter bit LCD_MODE = 1'b1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Phase switches
	input wire logic autoZeroSwitch,
	input wire logic signalIntegrateSwitch,
	input wire logic refRampPosSwitch,
	input wire logic refRampNegSwitch,
	input wire logic dischargeSwitch,
	input wire logic refChargeSwitch,
	// Display
	input wire logic backplaneDrive,
	input wire logic minusSegment
);
	logic [3:0] phase;
	logic [3:0] phase_q;
	logic [13:0] phCnt_q;
	logic [13:0] cycCnt_q;
	logic [8:0] bpCnt_q;
	logic bp_q;
	logic seen_q;
	logic ramp;
	logic minusLit;
	assign ramp = refRampPosSwitch | refRampNegSwitch;
	assign phase = {autoZeroSwitch, signalIntegrateSwitch, ramp, dischargeSwitch};
	assign minusLit = LCD_MODE ? minusSegment ^ backplaneDrive : !minusSegment;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q <= 4'h8;
			phCnt_q <= 14'h0;
			cycCnt_q <= 14'h0;
			bpCnt_q <= 9'h0;
			bp_q <= 1'b0;
			seen_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase;
			bp_q <= backplaneDrive;
			phCnt_q <= (phase != phase_q) ? 14'h0 : phCnt_q + 14'h1;
			cycCnt_q <= (phase_q[3] && !phase[3]) ? 14'h0 : cycCnt_q + 14'h1;
			bpCnt_q <= (backplaneDrive != bp_q) ? 9'h0 : bpCnt_q + 9'h1;
			seen_q <= seen_q | (phase_q[3] && !phase[3]);
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence sAzEnd;
		$fell(autoZeroSwitch);
	endsequence
	sequence sIntEnd;
		$fell(signalIntegrateSwitch);
	endsequence
	sequence sRampEnd;
		$fell(ramp);
	endsequence
	AST_BP_PERIOD: assert property (seen_q && $changed(backplaneDrive) |-> bpCnt_q == 9'h18f)
		else $error("Backplane half period wrong");
	AST_INT_LEN: assert property (sIntEnd |-> phCnt_q == 14'hf9f)
		else $error("Integrate length wrong");
	AST_DEINT_MAX: assert property (sRampEnd |-> phCnt_q <= 14'h1f3f)
		else $error("Deintegrate too long");
	AST_ZI_LEN: assert property ($fell(dischargeSwitch) |-> autoZeroSwitch && (phCnt_q == 14'h27 || phCnt_q == 14'he0f))
		else $error("Zero integrate length wrong");
	AST_AZ_LEN: assert property (sAzEnd ##0 seen_q |-> phCnt_q == 14'h18f || (phCnt_q >= 14'hf77 && phCnt_q <= 14'h2eb3))
		else $error("Auto-zero length wrong");
	AST_CYCLE: assert property (sAzEnd ##0 seen_q |-> cycCnt_q == 14'h3e7f)
		else $error("Cycle length wrong");
	AST_ORDER_INT: assert property (sAzEnd |-> signalIntegrateSwitch && !ramp)
		else $error("Integrate does not follow auto-zero");
	AST_ORDER_DE: assert property (sIntEnd |-> refRampPosSwitch ^ refRampNegSwitch)
		else $error("Deintegrate does not follow integrate");
	AST_ORDER_ZI: assert property (sRampEnd |-> dischargeSwitch)
		else $error("Zero integrate does not follow deintegrate");
	AST_REF_CHARGE: assert property (refChargeSwitch == (autoZeroSwitch | dischargeSwitch))
		else $error("Reference charge switch wrong");
	AST_SIGN_NEG: assert property ($fell(refRampPosSwitch) |-> ##[1:3] minusLit)
		else $error("Minus sign not lit");
	AST_SIGN_POS: assert property ($fell(refRampNegSwitch) |-> ##[1:3] !minusLit)
		else $error("Minus sign lit");
endmodule : dsc_seq_checker
bind dsc_sequencer_display dsc_seq_checker #(.LCD_MODE(LCD_MODE)) seqChk (.core_clk(core_clk), .rst_n(rst_n),
	.autoZeroSwitch(autoZeroSwitch), .signalIntegrateSwitch(signalIntegrateSwitch),
	.refRampPosSwitch(refRampPosSwitch), .refRampNegSwitch(refRampNegSwitch), .dischargeSwitch(dischargeSwitch),
	.refChargeSwitch(refChargeSwitch), .backplaneDrive(backplaneDrive), .minusSegment(minusSegment));
`default_nettype wire

/* dsc_display_model.sv */
// Purpose: Directly driven display, giving the lit pattern a viewer sees.
// Assumes: LCD lit means segment opposite to backplane; LED lit means pin low.
// Notes: Pattern order is {g,f,e,d,c,b,a}.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Display model
// ****************************************
module dsc_display_model #(
	parameter bit LCD_MODE = 1'b1
) (
	// Pins from the device
	input wire logic backplaneDrive,
	input wire logic [6:0] onesSegments,
	input wire logic [6:0] tensSegments,
	input wire logic [6:0] hundredsSegments,
	input wire logic halfDigitSegment,
	input wire logic minusSegment,
	// Lit pattern
	output logic [6:0] onesLit,
	output logic [6:0] tensLit,
	output logic [6:0] hundredsLit,
	output logic halfLit,
	output logic minusLit
);
	logic [6:0] ref7;
	assign ref7 = LCD_MODE ? {7{backplaneDrive}} : 7'h7f;
	assign onesLit = onesSegments ^ ref7;
	assign tensLit = tensSegments ^ ref7;
	assign hundredsLit = hundredsSegments ^ ref7;
	assign halfLit = halfDigitSegment ^ ref7[0];
	assign minusLit = minusSegment ^ ref7[0];
endmodule : dsc_display_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the sequencer and display drive.
// Assumes: The bench plays the comparator by timing its zero crossing.
// Notes: A crossing after k counts of deintegrate must read k.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module tb_top;
	logic core_clk, rst_n, compOut, autoZeroSwitch, signalIntegrateSwitch, refRampPosSwitch, refRampNegSwitch;
	logic dischargeSwitch, refChargeSwitch, backplaneDrive, halfDigitSegment, minusSegment, halfLit, minusLit;
	logic [6:0] onesSegments, tensSegments, hundredsSegments, onesLit, tensLit, hundredsLit;
	logic [2:0] watch;
	logic [6:0] segTab [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	assign watch = {dischargeSwitch, refRampPosSwitch | refRampNegSwitch, signalIntegrateSwitch};
	dsc_sequencer_display #(.LCD_MODE(1'b1)) DUT (.core_clk, .rst_n, .compOut, .autoZeroSwitch,
		.signalIntegrateSwitch, .refRampPosSwitch, .refRampNegSwitch, .dischargeSwitch, .refChargeSwitch,
		.backplaneDrive, .onesSegments, .tensSegments, .hundredsSegments, .halfDigitSegment, .minusSegment);
	dsc_display_model #(.LCD_MODE(1'b1)) display (.backplaneDrive, .onesSegments, .tensSegments,
		.hundredsSegments, .halfDigitSegment, .minusSegment, .onesLit, .tensLit, .hundredsLit, .halfLit, .minusLit);
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic waitSig(input int idx, input int lim);
		int n;
		n = 0;
		while (watch[idx] !== 1'b1 && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
		chk({7'h0, watch[idx]}, 8'h01);
	endtask : waitSig
	task automatic chkDisp(input int k, input logic neg, input logic over);
		chk({7'h0, halfLit}, {7'h0, over || k >= 1000});
		chk({1'b0, onesLit}, over ? 8'h00 : {1'b0, segTab[k % 10]});
		chk({1'b0, tensLit}, over ? 8'h00 : {1'b0, segTab[k / 10 % 10]});
		chk({1'b0, hundredsLit}, over ? 8'h00 : {1'b0, segTab[k / 100 % 10]});
		chk({7'h0, minusLit}, {7'h0, neg});
	endtask : chkDisp
	task automatic conv(input int k, input logic neg, input logic over);
		waitSig(0, 16000);
		@(posedge core_clk);
		compOut <= neg;
		waitSig(1, 4100);
		chk({7'h0, refRampPosSwitch}, {7'h0, neg});
		if (!over)
		begin
			repeat (4 * k + 1) @(posedge core_clk);
			compOut <= !neg;
		end
		waitSig(2, 8100);
		repeat (3) @(negedge core_clk);
		chkDisp(k, neg, over);
	endtask : conv
	task automatic testReset();
		repeat (3) @(negedge core_clk);
		chk({7'h0, autoZeroSwitch}, 8'h01);
		chkDisp(0, 1'b0, 1'b0);
		$display("testReset done");
	endtask : testReset
	task automatic testZero();
		conv(0, 1'b1, 1'b0);
		$display("testZero done");
	endtask : testZero
	task automatic testSmall();
		conv(5, 1'b0, 1'b0);
		$display("testSmall done");
	endtask : testSmall
	task automatic testFull();
		conv(1999, 1'b1, 1'b0);
		$display("testFull done");
	endtask : testFull
	task automatic testOver();
		conv(0, 1'b0, 1'b1);
		$display("testOver done");
	endtask : testOver
	task automatic testMidReset();
		waitSig(0, 16000);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk({7'h0, refChargeSwitch}, 8'h01);
		chkDisp(0, 1'b0, 1'b0);
		$display("testMidReset done");
	endtask : testMidReset
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		compOut = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		testReset();
		testZero();
		testSmall();
		testFull();
		testOver();
		testMidReset();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
